// >>> logic/gpio_pin_enable_top.sv
// Contract
// - Sixteen pins, 15 down to 0, each with enable and direction bits at its own index.
// - A pin acts as general-purpose only while its enable bit is 1.
// - For an enabled pin, direction 0 makes it an input and 1 an output driven by the device.
// - The direction bit has no influence on a pin whose enable bit is clear.
// - After reset all pins are inputs and all direction bits read zero. (Code: enable bits also reset to 0, so each pin's drive follows ALT_OE_N.)
// - The enable bits live in a read/write register at 01B0_0000.
// - The direction bits live in a read/write register at 01B0_0004.
//
// APB slave holding the pin enable and direction registers and the pin muxing.
// Assumes one clock, synchronous active-high reset; every access gets one wait state.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_enable_cfg.svh"

module gpio_pin_enable_top
    import gpio_pin_enable_pkg::*;
#(
    parameter int PINS = `GPIO_PIN_ENABLE_PIN_COUNT
) (
    input  wire logic            CLK_SYS,
    input  wire logic            RST,
    input  wire logic            PSEL,
    input  wire logic            PENABLE,
    input  wire logic            PWRITE,
    input  wire logic [31:0]     PADDR,
    input  wire logic [31:0]     PWDATA,
    input  wire logic [3:0]      PSTRB,
    output var  logic [31:0]     PRDATA,
    output var  logic            PREADY,
    output var  logic            PSLVERR,
    input  wire logic [PINS-1:0] GPIO_DATA_OUT,
    output var  logic [PINS-1:0] GPIO_DATA_IN,
    input  wire logic [PINS-1:0] ALT_OUT,
    input  wire logic [PINS-1:0] ALT_OE_N,
    input  wire logic [PINS-1:0] PIN_IN,
    output var  logic [PINS-1:0] PIN_OUT,
    output var  logic [PINS-1:0] PIN_OE_N
);
    gpio_pin_enable_cfg_t        cfg_r;
    logic [PINS-1:0]  pin_sync;
    logic             access;
    logic             done;
    gpio_pin_enable_sel_t        sel;

    // Byte-lane merge, used by both writable registers
    function automatic logic [PINS-1:0] merge(
        input logic [PINS-1:0] old_v,
        input logic [31:0]     wdata,
        input logic [3:0]      strb
    );
        logic [31:0] res;
        res = 32'(old_v);
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
        return res[PINS-1:0];
    endfunction

    always_comb begin
        unique case (PADDR)
            `GPIO_PIN_ENABLE_ENABLE_ADDR: sel = GPIO_PIN_ENABLE_SEL_ENABLE;
            `GPIO_PIN_ENABLE_DIR_ADDR:    sel = GPIO_PIN_ENABLE_SEL_DIR;
            `GPIO_PIN_ENABLE_STATUS_ADDR: sel = GPIO_PIN_ENABLE_SEL_STATUS;
            default:           sel = GPIO_PIN_ENABLE_SEL_NONE;
        endcase
    end

    // Two-cycle access phase (one wait state); PREADY is a registered pulse
    assign access = PSEL && PENABLE && !PREADY;
    // A write lands only at the edge where the master sees PREADY high
    assign done   = PSEL && PENABLE && PREADY;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            cfg_r.enable <= `GPIO_PIN_ENABLE_ENABLE_RST;
            cfg_r.dir    <= `GPIO_PIN_ENABLE_DIR_RST;
        end else if (done && PWRITE) begin
            if (sel == GPIO_PIN_ENABLE_SEL_ENABLE) begin
                cfg_r.enable <= merge(cfg_r.enable, PWDATA, PSTRB);
            end
            if (sel == GPIO_PIN_ENABLE_SEL_DIR) begin
                cfg_r.dir <= merge(cfg_r.dir, PWDATA, PSTRB);
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
        end else begin
            PREADY  <= access;
            PSLVERR <= access && (sel == GPIO_PIN_ENABLE_SEL_NONE);
            PRDATA  <= 32'h00000000;
            if (access && !PWRITE) begin
                unique case (sel)
                    GPIO_PIN_ENABLE_SEL_ENABLE: PRDATA <= {16'h0000, cfg_r.enable};
                    GPIO_PIN_ENABLE_SEL_DIR:    PRDATA <= {16'h0000, cfg_r.dir};
                    GPIO_PIN_ENABLE_SEL_STATUS: PRDATA <= {16'h0000, pin_sync};
                    GPIO_PIN_ENABLE_SEL_NONE:   PRDATA <= 32'h00000000;
                endcase
            end
        end
    end

    gpio_pin_enable_sync #(
        .WIDTH    (PINS)
    ) u_sync (
        .clk      (CLK_SYS),
        .rst      (RST),
        .async_in (PIN_IN),
        .sync_out (pin_sync)
    );

    // Pin mux; a disabled pin is handed to its alternate function
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            PIN_OUT      <= '0;
            PIN_OE_N     <= '1;
            GPIO_DATA_IN <= '0;
        end else begin
            for (int i = 0; i < PINS; i++) begin
                if (cfg_r.enable[i]) begin
                    PIN_OUT[i]  <= GPIO_DATA_OUT[i];
                    PIN_OE_N[i] <= !cfg_r.dir[i];
                end else begin
                    PIN_OUT[i]  <= ALT_OUT[i];
                    PIN_OE_N[i] <= ALT_OE_N[i];
                end
                // Input data is only meaningful while the pin is a GP input
                GPIO_DATA_IN[i] <= cfg_r.enable[i] && !cfg_r.dir[i] && pin_sync[i];
            end
        end
    end
endmodule

`default_nettype wire

// >>> logic/gpio_pin_enable_cfg.svh
// Register map and reset values for the enable/direction pin block.
// Assumes a 32-bit APB word map; included by bare name.
`ifndef GPIO_PIN_ENABLE_CFG_SVH
`define GPIO_PIN_ENABLE_CFG_SVH

`define GPIO_PIN_ENABLE_ENABLE_ADDR    32'h01B00000
`define GPIO_PIN_ENABLE_DIR_ADDR       32'h01B00004
`define GPIO_PIN_ENABLE_STATUS_ADDR    32'h01B00008
`define GPIO_PIN_ENABLE_ENABLE_RST     16'h0000
`define GPIO_PIN_ENABLE_DIR_RST        16'h0000
`define GPIO_PIN_ENABLE_PIN_COUNT      16

`endif

// >>> logic/gpio_pin_enable_pkg.sv
// Types shared by the pin enable/direction block.
// Assumes the cfg header supplies the numbers.
`include "gpio_pin_enable_cfg.svh"

package gpio_pin_enable_pkg;
    typedef enum {
        GPIO_PIN_ENABLE_SEL_NONE,
        GPIO_PIN_ENABLE_SEL_ENABLE,
        GPIO_PIN_ENABLE_SEL_DIR,
        GPIO_PIN_ENABLE_SEL_STATUS
    } gpio_pin_enable_sel_t;

    typedef struct packed {
        logic [`GPIO_PIN_ENABLE_PIN_COUNT-1:0] enable;
        logic [`GPIO_PIN_ENABLE_PIN_COUNT-1:0] dir;
    } gpio_pin_enable_cfg_t;
endpackage

// >>> logic/gpio_pin_enable_sync.sv
// Two-flop synchroniser for the pin input levels.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_enable_sync #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

`default_nettype wire

// >>> bench/gpio_pin_enable_asserts.sv
// Checker for the pin enable/direction block.
// Sees top ports only; a shadow of both registers is kept from APB writes.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_enable_cfg.svh"
module gpio_pin_enable_asserts #(parameter int PINS = 16) (
    input wire logic CLK_SYS, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
    input wire logic [31:0] PADDR, PWDATA, PRDATA,
    input wire logic [3:0] PSTRB,
    input wire logic [PINS-1:0] GPIO_DATA_OUT, GPIO_DATA_IN, ALT_OUT, ALT_OE_N,
    input wire logic [PINS-1:0] PIN_OUT, PIN_OE_N
);
logic [PINS-1:0] en_r, dir_r;
wire [PINS-1:0] m = PINS'({{8{PSTRB[1]}}, {8{PSTRB[0]}}});
wire [PINS-1:0] inp = en_r & ~dir_r;
wire wr = PSEL & PENABLE & PREADY & PWRITE;
wire mp = PADDR inside {`GPIO_PIN_ENABLE_ENABLE_ADDR, `GPIO_PIN_ENABLE_DIR_ADDR, `GPIO_PIN_ENABLE_STATUS_ADDR};
always_ff @(posedge CLK_SYS) begin
    if (RST) en_r <= '0;
    else if (wr && PADDR == `GPIO_PIN_ENABLE_ENABLE_ADDR) en_r <= en_r & ~m | PWDATA[PINS-1:0] & m;
end
always_ff @(posedge CLK_SYS) begin
    if (RST) dir_r <= '0;
    else if (wr && PADDR == `GPIO_PIN_ENABLE_DIR_ADDR) dir_r <= dir_r & ~m | PWDATA[PINS-1:0] & m;
end
default clocking @(posedge CLK_SYS); endclocking
default disable iff (RST);
chk_ready_next: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("late");
chk_ready_once: assert property (PREADY |=> !PREADY) else $error("long ready");
chk_err_map: assert property (PREADY |-> PSLVERR == !mp) else $error("bad err");
chk_read_en: assert property (PREADY && !PWRITE && PADDR == `GPIO_PIN_ENABLE_ENABLE_ADDR
    |-> PRDATA == 32'(en_r)) else $error("enable read");
chk_read_dir: assert property (PREADY && !PWRITE && PADDR == `GPIO_PIN_ENABLE_DIR_ADDR
    |-> PRDATA == 32'(dir_r)) else $error("direction read");
chk_pin_oe: assert property (1 |=> PIN_OE_N == $past(inp | ~en_r & ALT_OE_N))
    else $error("pin enable");
chk_pin_out: assert property (1 |=> PIN_OUT == $past(en_r & GPIO_DATA_OUT | ~en_r & ALT_OUT))
    else $error("pin drive");
chk_in_mask: assert property ((GPIO_DATA_IN & ~inp & ~$past(inp)) == 0) else $error("in");
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Bench for the pin enable/direction block.
// Drives APB and pins itself; no partner model.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_enable_cfg.svh"
module testbench;
localparam logic [15:0] E = 16'hA5C3, D = 16'h33F0;
logic CLK_SYS = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, er;
logic [31:0] PADDR = '0, PWDATA = '0, PRDATA, rd;
logic [3:0] PSTRB = '0;
logic [15:0] GPIO_DATA_OUT = 16'h9696, ALT_OUT = 16'h3C5A, ALT_OE_N = 16'hFFFF, PIN_IN = '0;
logic [15:0] GPIO_DATA_IN, PIN_OUT, PIN_OE_N;
int failures = 0, n_tests = 0, cyc = 0;
always #50 CLK_SYS = ~CLK_SYS;
gpio_pin_enable_top DUT (.*);
always @(posedge CLK_SYS) if (++cyc > 2000) begin failures++; close_out; end
task chk(string s, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin failures++; $display("MISMATCH %s exp %h got %h", s, e, g); end
endtask
task apb(logic w, logic [31:0] a, logic [31:0] d, logic [3:0] s);
    PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d; PSTRB <= s;
    @(posedge CLK_SYS) PENABLE <= 1;
    do @(posedge CLK_SYS); while (PREADY !== 1);
    rd = PRDATA; er = PSLVERR;
    PSEL <= 0; PENABLE <= 0;
    // Idle edge so the next setup never re-drives psel in the same step
    @(posedge CLK_SYS);
endtask
task t_reset;
    apb(0, `GPIO_PIN_ENABLE_ENABLE_ADDR, 0, 0); chk("en", 0, rd);
    apb(0, `GPIO_PIN_ENABLE_DIR_ADDR, 0, 0); chk("dir", 0, rd);
    chk("oe", 16'hFFFF, PIN_OE_N); chk("out", ALT_OUT, PIN_OUT);
endtask
task t_regs;
    apb(1, `GPIO_PIN_ENABLE_ENABLE_ADDR, 32'hFFFFA5C3, 4'hF);
    apb(0, `GPIO_PIN_ENABLE_ENABLE_ADDR, 0, 0); chk("en", 32'(E), rd);
    apb(1, `GPIO_PIN_ENABLE_DIR_ADDR, 32'h00000FF0, 4'h1);
    apb(1, `GPIO_PIN_ENABLE_DIR_ADDR, 32'h00003300, 4'h2);
    apb(0, `GPIO_PIN_ENABLE_DIR_ADDR, 0, 0); chk("dir", 32'(D), rd);
    apb(1, 32'h01B0000C, 32'hFFFFFFFF, 4'hF); chk("werr", 1, er);
    apb(0, 32'h01B0000C, 0, 0); chk("rerr", 1, er); chk("rz", 0, rd);
    apb(0, `GPIO_PIN_ENABLE_ENABLE_ADDR, 0, 0); chk("keep", 32'(E), rd);
endtask
task t_pins;
    PIN_IN <= 16'hFFFF;
    repeat (6) @(posedge CLK_SYS);
    chk("oe", E & ~D | ~E & ALT_OE_N, PIN_OE_N);
    chk("out", E & GPIO_DATA_OUT | ~E & ALT_OUT, PIN_OUT);
    chk("in", E & ~D, GPIO_DATA_IN);
    apb(0, `GPIO_PIN_ENABLE_STATUS_ADDR, 0, 0); chk("st", 32'h0000FFFF, rd);
endtask
task close_out;
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask
initial begin
    repeat (2) @(posedge CLK_SYS);
    RST <= 0;
    @(posedge CLK_SYS);
    t_reset;
    t_regs;
    t_pins;
    close_out;
end
endmodule
bind gpio_pin_enable_top gpio_pin_enable_asserts #(.PINS(PINS)) u_chk (.*);
`default_nettype wire
